// File: core/lmb_core.sv
// Multiplex scan, blink timing and brightness core with its control registers.
`timescale 1ns/1ns
module lmb_core #(
  parameter int unsigned BLINK_SLOW_TICKS = lmb_pkg::BLINK_SLOW_TICKS
) (
  // Clock and reset
  input  wire logic        clk_sys_in,
  input  wire logic        rstn_in,
  // Register port
  input  wire logic [6:0]  reg_addr_in,
  input  wire logic [7:0]  reg_wdata_in,
  input  wire logic        reg_wr_in,
  input  wire logic        reg_rd_in,
  output logic      [7:0]  reg_rdata_out,
  // Multiplex clock
  input  wire logic        multiplex_clock_input_in,
  input  wire logic        ext_clock_select_in,
  output logic             multiplex_clock_copy_output_out,
  // Display drive
  output logic      [7:0]  digit_enable_out,
  output logic      [7:0]  digit_extra_enable_out,
  output logic      [15:0] segment16_out,
  output logic             decimal_point_segment_out,
  output logic      [15:0] segment7_out,
  output logic      [7:0]  key_scan_slot_mask_out,
  output logic             blink_phase_out
);
  import lmb_pkg::*;

  localparam int unsigned BLINK_FAST_TICKS = BLINK_SLOW_TICKS / 2;

  logic [1:0]  osc_sync_r;
  logic [1:0]  sel_sync_r;
  logic        osc_prev_r;
  logic [4:0]  osc_cnt_r;
  logic        int_clk_r;
  logic        shutdown_r;
  logic        blink_fast_r;
  logic        blink_en_r;
  logic        per_digit_r;
  logic        phase_r;
  logic [22:0] blink_cnt_r;
  logic [7:0]  global_r;
  logic [7:0]  scan_r;
  logic [7:0]  bright_r [0:7];
  logic [7:0]  plane0_r [0:15];
  logic [7:0]  plane1_r [0:15];
  logic [5:0]  step_cnt_r;
  logic [3:0]  pwm_step_r;
  logic [2:0]  slot_r;
  logic        ext_rise;
  logic        int_rise;
  logic        mux_tick;
  logic        step_end;
  logic        digit_end;
  logic        cfg_wr;
  logic        blink_restart;
  logic        digit_clear;
  logic        plane_sel;
  logic [7:0]  code_main;
  logic [7:0]  code_extra;
  logic [15:0] glyph16_main;
  logic [6:0]  glyph7_main;
  logic [6:0]  glyph7_extra;
  logic [3:0]  nib_main;
  logic [3:0]  nib_extra;
  logic [22:0] blink_term;
  logic [7:0]  rdata_nxt;

  function automatic logic [3:0] pick_nibble(input logic [7:0] val, input logic odd);
    return odd ? val[7:4] : val[3:0];
  endfunction

  // Setting 15 shares the top step with 14 so the last sixteenth always stays dark.
  function automatic logic [3:0] duty_of(input logic [3:0] nib);
    return (nib == 4'hf) ? 4'hf : nib + 4'h1;
  endfunction

  function automatic logic [7:0] slot_onehot(input logic [2:0] slot);
    return 8'h01 << slot;
  endfunction

  // The oscillator pin and its select strap come from outside and are synchronised first.
  always_ff @(posedge clk_sys_in) begin
    if (!rstn_in) begin
      osc_sync_r <= 2'h0;
      sel_sync_r <= 2'h0;
      osc_prev_r <= 1'b0;
    end else begin
      osc_sync_r <= {osc_sync_r[0], multiplex_clock_input_in};
      sel_sync_r <= {sel_sync_r[0], ext_clock_select_in};
      osc_prev_r <= osc_sync_r[1];
    end
  end

  // Internal oscillator model; it is frozen while shut down to save power.
  always_ff @(posedge clk_sys_in) begin
    if (!rstn_in) begin
      osc_cnt_r <= 5'h00;
      int_clk_r <= 1'b0;
    end else if (!shutdown_r) begin
      if (osc_cnt_r == 5'(OSC_HALF_CYCLES - 1)) begin
        osc_cnt_r <= 5'h00;
        int_clk_r <= ~int_clk_r;
      end else begin
        osc_cnt_r <= osc_cnt_r + 5'h01;
      end
    end
  end

  assign ext_rise = osc_sync_r[1] & ~osc_prev_r;
  assign int_rise = !shutdown_r && !int_clk_r && (osc_cnt_r == 5'(OSC_HALF_CYCLES - 1));
  assign mux_tick = sel_sync_r[1] ? ext_rise : int_rise;

  always_ff @(posedge clk_sys_in) begin
    if (!rstn_in) begin
      multiplex_clock_copy_output_out <= 1'b0;
    end else begin
      multiplex_clock_copy_output_out <= sel_sync_r[1] ? osc_sync_r[1] : int_clk_r;
    end
  end

  assign cfg_wr        = reg_wr_in && (reg_addr_in == ADDR_CONFIG);
  assign blink_restart = cfg_wr && reg_wdata_in[CFG_BLINK_RST];
  assign digit_clear   = cfg_wr && reg_wdata_in[CFG_CLEAR];

  // Stored control bits; the transient and phase positions are never kept here.
  always_ff @(posedge clk_sys_in) begin
    if (!rstn_in) begin
      shutdown_r   <= 1'b1;
      blink_fast_r <= 1'b0;
      blink_en_r   <= 1'b0;
      per_digit_r  <= 1'b0;
    end else if (cfg_wr) begin
      shutdown_r   <= reg_wdata_in[CFG_SHUTDOWN];
      blink_fast_r <= reg_wdata_in[CFG_BLINK_FAST];
      blink_en_r   <= reg_wdata_in[CFG_BLINK_EN];
      per_digit_r  <= reg_wdata_in[CFG_PER_DIGIT];
    end
  end

  always_ff @(posedge clk_sys_in) begin
    if (!rstn_in) begin
      global_r <= BRIGHT_RESET;
      scan_r   <= SCAN_RESET;
      for (int i = 0; i < 8; i++) begin
        bright_r[i] <= BRIGHT_RESET;
      end
    end else if (reg_wr_in) begin
      if (reg_addr_in == ADDR_GLOBAL_BRIGHT) begin
        global_r <= reg_wdata_in;
      end
      if (reg_addr_in == ADDR_SCAN_LIMIT) begin
        scan_r <= reg_wdata_in;
      end
      if (reg_addr_in[6:3] == ADDR_BRIGHT_BASE[6:3]) begin
        bright_r[reg_addr_in[2:0]] <= reg_wdata_in;
      end
    end
  end

  // Digit memory, two planes of sixteen digits each.
  always_ff @(posedge clk_sys_in) begin
    if (!rstn_in || digit_clear) begin
      for (int i = 0; i < 16; i++) begin
        plane0_r[i] <= DIGIT_BLANK;
        plane1_r[i] <= DIGIT_BLANK;
      end
    end else if (reg_wr_in) begin
      if (reg_addr_in[6:4] == ADDR_PLANE0_BASE[6:4]) begin
        plane0_r[reg_addr_in[3:0]] <= reg_wdata_in;
      end
      if (reg_addr_in[6:4] == ADDR_PLANE1_BASE[6:4]) begin
        plane1_r[reg_addr_in[3:0]] <= reg_wdata_in;
      end
    end
  end

  // Blink divider; the fast count is half the slow one.
  assign blink_term = blink_fast_r ? 23'(BLINK_FAST_TICKS) : 23'(BLINK_SLOW_TICKS);

  always_ff @(posedge clk_sys_in) begin
    if (!rstn_in || blink_restart) begin
      blink_cnt_r <= 23'h000000;
      phase_r     <= 1'b0;
    end else if (mux_tick) begin
      if (blink_cnt_r >= blink_term - 23'h000001) begin
        blink_cnt_r <= 23'h000000;
        phase_r     <= ~phase_r;
      end else begin
        blink_cnt_r <= blink_cnt_r + 23'h000001;
      end
    end
  end

  // Scan pacing: sixteen PWM steps make one digit period.
  assign step_end  = mux_tick && (step_cnt_r == 6'(STEP_TICKS - 1));
  assign digit_end = step_end && (pwm_step_r == 4'(PWM_STEPS - 1));

  always_ff @(posedge clk_sys_in) begin
    if (!rstn_in) begin
      step_cnt_r <= 6'h00;
      pwm_step_r <= 4'h0;
    end else if (step_end) begin
      step_cnt_r <= 6'h00;
      pwm_step_r <= pwm_step_r + 4'h1;
    end else if (mux_tick) begin
      step_cnt_r <= step_cnt_r + 6'h01;
    end
  end

  // Lowering the limit mid-scan must not strand the scan above it, hence the >= test.
  always_ff @(posedge clk_sys_in) begin
    if (!rstn_in) begin
      slot_r <= 3'h0;
    end else if (digit_end) begin
      slot_r <= (slot_r >= scan_r[2:0]) ? 3'h0 : slot_r + 3'h1;
    end
  end

  assign plane_sel  = blink_en_r && phase_r;
  assign code_main  = plane_sel ? plane1_r[{1'b0, slot_r}] : plane0_r[{1'b0, slot_r}];
  assign code_extra = plane_sel ? plane1_r[{1'b1, slot_r}] : plane0_r[{1'b1, slot_r}];

  lmb_font_rom u_font_main (
    .code_in     (code_main[6:0]),
    .glyph16_out (glyph16_main),
    .glyph7_out  (glyph7_main)
  );

  lmb_font_rom u_font_extra (
    .code_in     (code_extra[6:0]),
    .glyph16_out (),
    .glyph7_out  (glyph7_extra)
  );

  assign nib_main  = per_digit_r ? pick_nibble(bright_r[{1'b0, slot_r[2:1]}], slot_r[0])
                                 : global_r[3:0];
  assign nib_extra = per_digit_r ? pick_nibble(bright_r[{1'b1, slot_r[2:1]}], slot_r[0])
                                 : global_r[3:0];

  always_ff @(posedge clk_sys_in) begin
    if (!rstn_in) begin
      digit_enable_out       <= 8'h00;
      digit_extra_enable_out <= 8'h00;
    end else begin
      digit_enable_out       <= (!shutdown_r && pwm_step_r < duty_of(nib_main))
                                ? slot_onehot(slot_r) : 8'h00;
      digit_extra_enable_out <= (!shutdown_r && pwm_step_r < duty_of(nib_extra))
                                ? slot_onehot(slot_r) : 8'h00;
    end
  end

  always_ff @(posedge clk_sys_in) begin
    if (!rstn_in) begin
      segment16_out             <= 16'h0000;
      decimal_point_segment_out <= 1'b0;
      segment7_out              <= 16'h0000;
    end else begin
      segment16_out             <= glyph16_main;
      decimal_point_segment_out <= code_main[7];
      segment7_out              <= {code_extra[7], glyph7_extra, code_main[7], glyph7_main};
    end
  end

  always_ff @(posedge clk_sys_in) begin
    if (!rstn_in) begin
      key_scan_slot_mask_out <= 8'h01;
      blink_phase_out        <= 1'b0;
    end else begin
      key_scan_slot_mask_out <= 8'((9'h002 << scan_r[2:0]) - 9'h001);
      blink_phase_out        <= phase_r;
    end
  end

  // Read side: transient bits read back as zero and the phase bit is live.
  always_comb begin
    rdata_nxt = 8'h00;
    if (reg_addr_in == ADDR_GLOBAL_BRIGHT) begin
      rdata_nxt = global_r;
    end else if (reg_addr_in == ADDR_SCAN_LIMIT) begin
      rdata_nxt = scan_r;
    end else if (reg_addr_in == ADDR_CONFIG) begin
      rdata_nxt[CFG_SHUTDOWN]   = shutdown_r;
      rdata_nxt[CFG_BLINK_FAST] = blink_fast_r;
      rdata_nxt[CFG_BLINK_EN]   = blink_en_r;
      rdata_nxt[CFG_PER_DIGIT]  = per_digit_r;
      rdata_nxt[CFG_PHASE]      = phase_r;
    end else if (reg_addr_in[6:3] == ADDR_BRIGHT_BASE[6:3]) begin
      rdata_nxt = bright_r[reg_addr_in[2:0]];
    end else if (reg_addr_in[6:4] == ADDR_PLANE0_BASE[6:4]) begin
      rdata_nxt = plane0_r[reg_addr_in[3:0]];
    end else if (reg_addr_in[6:4] == ADDR_PLANE1_BASE[6:4]) begin
      rdata_nxt = plane1_r[reg_addr_in[3:0]];
    end
  end

  always_ff @(posedge clk_sys_in) begin
    if (!rstn_in) begin
      reg_rdata_out <= 8'h00;
    end else if (reg_rd_in) begin
      reg_rdata_out <= rdata_nxt;
    end
  end

  // Checks.
  default clocking cb @(posedge clk_sys_in); endclocking
  default disable iff (!rstn_in);

  reset_state_a: assert property ($rose(rstn_in) |-> shutdown_r && global_r == 8'h00 && !blink_en_r)
    else $error("state after reset is not shutdown with minimum intensity");
  osc_stopped_a: assert property (shutdown_r && $past(shutdown_r) |-> $stable(int_clk_r) && !int_rise)
    else $error("internal oscillator ran during shutdown");
  dark_in_shutdown_a: assert property (shutdown_r |=> digit_enable_out == 8'h00
                                       && digit_extra_enable_out == 8'h00)
    else $error("digit driven while shut down");
  blink_restart_a: assert property (blink_restart |=> blink_cnt_r == 23'h000000 && !phase_r)
    else $error("blink timing not restarted");
  transient_read_a: assert property (reg_rd_in && reg_addr_in == ADDR_CONFIG |=>
                                     !reg_rdata_out[CFG_BLINK_RST] && !reg_rdata_out[CFG_CLEAR]
                                     && reg_rdata_out[CFG_PHASE] == $past(phase_r))
    else $error("control readback shows transient bits or wrong phase");
  clear_digits_a: assert property (digit_clear |=> plane0_r[0] == DIGIT_BLANK && plane1_r[15] == DIGIT_BLANK)
    else $error("digit clear left data behind");
  blank_gap_a: assert property (pwm_step_r == 4'hf |=> digit_enable_out == 8'h00
                                && digit_extra_enable_out == 8'h00)
    else $error("no blanking in last sixteenth");
  global_duty_a: assert property (!per_digit_r && !shutdown_r && pwm_step_r < duty_of(global_r[3:0])
                                  |=> digit_enable_out == $past(slot_onehot(slot_r)))
    else $error("global duty not applied");
  slot_wrap_a: assert property (digit_end && slot_r >= scan_r[2:0] |=> slot_r == 3'h0)
    else $error("scan did not wrap at the limit");
  plane_zero_a: assert property (!blink_en_r
                                 |=> decimal_point_segment_out == $past(plane0_r[{1'b0, slot_r}][7]))
    else $error("plane one shown with blinking off");
  fast_half_a: assert property (mux_tick && blink_fast_r && blink_cnt_r == 23'(BLINK_FAST_TICKS - 1)
                                && !blink_restart |=> phase_r != $past(phase_r))
    else $error("fast blink phase did not toggle at half count");

  wake_c: cover property (shutdown_r ##1 !shutdown_r);
  phase_flip_c: cover property (mux_tick ##1 $changed(phase_r));
  wrap_c: cover property (digit_end && slot_r != 3'h0 ##1 slot_r == 3'h0);
  clear_c: cover property (digit_clear);
endmodule

// File: core/lmb_font_rom.sv
// Character generator holding the 104 glyph font.
`timescale 1ns/1ns
module lmb_font_rom (
  // Character code
  input  wire logic [6:0]  code_in,
  // Glyphs
  output logic      [15:0] glyph16_out,
  output logic      [6:0]  glyph7_out
);
  import lmb_pkg::*;

  // Hex glyphs keep the seven-segment pattern in their low bits so both fonts share entries.
  localparam logic [15:0] FONT [0:FONT_SIZE-1] = '{
    16'h003f, 16'h0006, 16'h005b, 16'h004f, 16'h0066, 16'h006d, 16'h007d, 16'h0007,
    16'h007f, 16'h006f, 16'h0077, 16'h007c, 16'h0039, 16'h005e, 16'h0079, 16'h0071,
    16'h2400, 16'h0900, 16'h3f00, 16'h1280, 16'h1200, 16'h0c00, 16'h0080, 16'h0400,
    16'h44ff, 16'h040c, 16'h8877, 16'h083f, 16'h888c, 16'h90b3, 16'h88fb, 16'h000f,
    16'h88ff, 16'h88bf, 16'h2200, 16'h2400, 16'h9400, 16'h8830, 16'h4900, 16'h2807,
    16'h0af7, 16'h88cf, 16'h2a3f, 16'h00f3, 16'h223f, 16'h80f3, 16'h80c3, 16'h08fb,
    16'h88cc, 16'h2233, 16'h007c, 16'h94c0, 16'h00f0, 16'h05cc, 16'h11cc, 16'h00ff,
    16'h88c7, 16'h10ff, 16'h98c7, 16'h88bb, 16'h2203, 16'h00fc, 16'h44c0, 16'h50cc,
    16'h5500, 16'h2500, 16'h4433, 16'h2212, 16'h1100, 16'h2221, 16'h5000, 16'h0030,
    16'h0100, 16'ha070, 16'ha0e0, 16'h8060, 16'h281c, 16'hc060, 16'haa02, 16'ha2a1,
    16'ha0c0, 16'h2000, 16'h2260, 16'h3600, 16'h00c0, 16'ha848, 16'ha040, 16'ha060,
    16'he0c1, 16'ha281, 16'h8040, 16'ha0a1, 16'h80e0, 16'h2060, 16'h4040, 16'h5048,
    16'h5500, 16'h0a1c, 16'hc020, 16'ha212, 16'h2200, 16'h2a21, 16'h8c01, 16'h0000
  };

  function automatic int font_index(input logic [6:0] code);
    if (code < 7'(FONT_HEX_COUNT)) begin
      return int'(code);
    end
    return int'(code - FONT_ASCII_FIRST) + FONT_HEX_COUNT;
  endfunction

  always_comb begin
    glyph16_out = 16'h0000;
    glyph7_out  = 7'h00;
    if (code_in < 7'(FONT_HEX_COUNT)) begin
      glyph16_out = FONT[font_index(code_in)];
      glyph7_out  = FONT[font_index(code_in)][6:0];
    end else if (code_in >= FONT_ASCII_FIRST) begin
      glyph16_out = FONT[font_index(code_in)];
    end
  end
endmodule

// File: core/lmb_pkg.sv
// Package of constants for the LED multiplex, blink and brightness core.
// How it works
// - One blink rate applies to whole display.
// - Reset clears registers, blanks, dims, enters shutdown.
// - Control register carries seven control bits.
// - Shutdown bit is read/write, clear selects normal operation.
// - Blink enable bit switches blinking display-wide.
// - Timing reset bit restarts blink, never stored.
// - Clear bit blanks every digit, both planes.
// - Phase bit reads blink phase, writes ignored.
// - Low seven bits index font; top bit decimal.
// - Font holds 104 glyphs, ASCII from 0x28.
// - First sixteen glyphs are hex, used for 7-segment.
// - Multiplex clock paces refresh, 200 us per digit.
// - Blink divider gives 0.5 or 1 Hz.
// - Clock copy output follows selected multiplex clock.
// - Internal oscillator stops during shutdown.
// - Scan limit selects one to eight slots.
// - Key scan limited to enabled digit slots.
// - Global mode takes duty from register 0x02.
// - Sixteen duty steps, always 1/16 blanking gap.
// - Per-digit mode uses each digit's own nibble.
// - Blinking alternates planes; otherwise plane zero only.
package lmb_pkg;
  // Register addresses.
  localparam logic [6:0] ADDR_GLOBAL_BRIGHT = 7'h02;
  localparam logic [6:0] ADDR_SCAN_LIMIT    = 7'h03;
  localparam logic [6:0] ADDR_CONFIG        = 7'h04;
  localparam logic [6:0] ADDR_BRIGHT_BASE   = 7'h10;
  localparam logic [6:0] ADDR_PLANE0_BASE   = 7'h20;
  localparam logic [6:0] ADDR_PLANE1_BASE   = 7'h40;
  // Control register bit positions.
  localparam int CFG_SHUTDOWN   = 0;
  localparam int CFG_BLINK_FAST = 2;
  localparam int CFG_BLINK_EN   = 3;
  localparam int CFG_BLINK_RST  = 4;
  localparam int CFG_CLEAR      = 5;
  localparam int CFG_PER_DIGIT  = 6;
  localparam int CFG_PHASE      = 7;
  // Reset and clear values.
  localparam logic [7:0] DIGIT_BLANK  = 8'h20;
  localparam logic [7:0] BRIGHT_RESET = 8'h00;
  localparam logic [7:0] SCAN_RESET   = 8'h00;
  // Font layout.
  localparam int FONT_SIZE       = 104;
  localparam int FONT_HEX_COUNT  = 16;
  localparam logic [6:0] FONT_ASCII_FIRST = 7'h28;
  // Timing.
  localparam int SYS_PERIOD_NS    = 8;
  localparam int OSC_PERIOD_NS    = 250;
  localparam int OSC_HALF_CYCLES  = OSC_PERIOD_NS / 2 / SYS_PERIOD_NS;
  localparam int MUX_CLK_HZ       = 4_000_000;
  localparam int DIGIT_TIME_US    = 200;
  localparam int DIGIT_TICKS      = int'(longint'(DIGIT_TIME_US) * MUX_CLK_HZ / 1_000_000);
  localparam int PWM_STEPS        = 16;
  localparam int STEP_TICKS       = DIGIT_TICKS / PWM_STEPS;
  localparam int BLINK_SLOW_MHZ   = 500;
  localparam int BLINK_SLOW_TICKS = int'(longint'(MUX_CLK_HZ) * 1000 / (2 * BLINK_SLOW_MHZ));
endpackage

// File: test/lmb_led_model.sv
// Behavioural digit driver load with an external multiplex clock source.
`timescale 1ns/1ns
module lmb_led_model #(
  parameter int EXT_HALF_NS = 64
) (
  // Clock and source control
  input  wire logic        clk_sys_in,
  input  wire logic        run_in,
  // Digit drive from the core
  input  wire logic [7:0]  digit_enable_in,
  input  wire logic [7:0]  digit_extra_enable_in,
  // Clock source and measurements
  output logic             ext_clock_out,
  output logic      [15:0] width_main_out,
  output logic      [15:0] width_extra_out,
  output logic      [15:0] period_main_out,
  output logic      [15:0] pulses_out
);
  logic [15:0] cnt_main_r = 16'h0000;
  logic [15:0] cnt_extra_r = 16'h0000;
  logic [15:0] since_r = 16'h0000;
  logic        main_d_r = 1'b0;
  logic        extra_d_r = 1'b0;
  // A 7.8 MHz source keeps the run short; it stands still while not running.
  initial begin
    ext_clock_out = 1'b0;
    width_main_out = 16'h0000;
    width_extra_out = 16'h0000;
    period_main_out = 16'h0000;
    pulses_out = 16'h0000;
    #3;
    forever begin
      #(EXT_HALF_NS);
      if (run_in) ext_clock_out = ~ext_clock_out;
    end
  end
  always @(posedge clk_sys_in) begin
    main_d_r <= digit_enable_in[0];
    extra_d_r <= digit_extra_enable_in[0];
    cnt_main_r <= digit_enable_in[0] ? cnt_main_r + 16'h0001 : 16'h0000;
    cnt_extra_r <= digit_extra_enable_in[0] ? cnt_extra_r + 16'h0001 : 16'h0000;
    since_r <= since_r + 16'h0001;
    if (digit_enable_in[0] && !main_d_r) begin
      period_main_out <= since_r;
      since_r <= 16'h0001;
    end
    if (!digit_enable_in[0] && main_d_r) begin
      width_main_out <= cnt_main_r;
      pulses_out <= pulses_out + 16'h0001;
    end
    if (!digit_extra_enable_in[0] && extra_d_r) width_extra_out <= cnt_extra_r;
  end
endmodule

// File: test/test_led_mux_blink_intensity_core.sv
// Self-checking bench for the multiplex, blink and brightness core.
`timescale 1ns/1ns
module test_led_mux_blink_intensity_core;
  import lmb_pkg::*;
  localparam int BT = 40;
  localparam int TC = 16;
  localparam int SC = STEP_TICKS * TC;
  localparam int PH = BT * TC;
  logic        clk_sys_in = 1'b0;
  logic        rstn_in = 1'b0;
  logic [6:0]  reg_addr_in = 7'h00;
  logic [7:0]  reg_wdata_in = 8'h00;
  logic        reg_wr_in = 1'b0;
  logic        reg_rd_in = 1'b0;
  logic        ext_clock_select_in = 1'b0;
  logic        ext_run = 1'b0;
  wire         ext_clk;
  wire  [7:0]  rdata, den, dex, kmask;
  wire  [15:0] seg16, seg7, w_main, w_extra, per_main, pulses;
  wire         clk_copy, dp, phase;
  int          n_errors = 0;
  int          samples_checked = 0;
  int          cyc = 0;
  lmb_core #(.BLINK_SLOW_TICKS(BT)) DUT (.clk_sys_in(clk_sys_in), .rstn_in(rstn_in), .reg_addr_in(reg_addr_in),
    .reg_wdata_in(reg_wdata_in), .reg_wr_in(reg_wr_in), .reg_rd_in(reg_rd_in), .reg_rdata_out(rdata),
    .multiplex_clock_input_in(ext_clk), .ext_clock_select_in(ext_clock_select_in),
    .multiplex_clock_copy_output_out(clk_copy), .digit_enable_out(den), .digit_extra_enable_out(dex),
    .segment16_out(seg16), .decimal_point_segment_out(dp), .segment7_out(seg7),
    .key_scan_slot_mask_out(kmask), .blink_phase_out(phase));
  lmb_led_model u_led (.clk_sys_in(clk_sys_in), .run_in(ext_run), .digit_enable_in(den),
    .digit_extra_enable_in(dex), .ext_clock_out(ext_clk), .width_main_out(w_main),
    .width_extra_out(w_extra), .period_main_out(per_main), .pulses_out(pulses));
  initial begin
    forever #4 clk_sys_in = ~clk_sys_in;
  end
  task automatic report_and_stop();
    $display("checks=%0d errors=%0d", samples_checked, n_errors);
    if (n_errors == 0 && samples_checked > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  always @(posedge clk_sys_in) begin
    cyc <= cyc + 1;
    if (cyc == 90000) begin
      n_errors++;
      report_and_stop();
    end
  end
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    samples_checked++;
    if (got !== exp) begin
      n_errors++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic rng(input logic [15:0] got, input int exp);
    samples_checked++;
    if ($isunknown(got) || got + 32 < exp || got > exp + 32) begin
      n_errors++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp[15:0]);
    end
  endtask
  task automatic wr(input logic [6:0] a, input logic [7:0] d);
    @(posedge clk_sys_in);
    reg_addr_in <= a;
    reg_wdata_in <= d;
    reg_wr_in <= 1'b1;
    @(posedge clk_sys_in);
    reg_wr_in <= 1'b0;
  endtask
  task automatic rd(input logic [6:0] a, input logic [7:0] exp);
    @(posedge clk_sys_in);
    reg_addr_in <= a;
    reg_rd_in <= 1'b1;
    @(posedge clk_sys_in);
    reg_rd_in <= 1'b0;
    @(posedge clk_sys_in);
    #1 chk({8'h00, rdata}, {8'h00, exp});
  endtask
  task automatic t_reset();
    logic seen;
    rd(ADDR_CONFIG, 8'h01);
    rd(ADDR_GLOBAL_BRIGHT, BRIGHT_RESET);
    rd(ADDR_SCAN_LIMIT, SCAN_RESET);
    for (int i = 0; i < 8; i++) rd(ADDR_BRIGHT_BASE + 7'(i), BRIGHT_RESET);
    for (int i = 0; i < 16; i++) rd(ADDR_PLANE0_BASE + 7'(i), DIGIT_BLANK);
    for (int i = 0; i < 16; i++) rd(ADDR_PLANE1_BASE + 7'(i), DIGIT_BLANK);
    chk({8'h00, kmask}, 16'h0001);
    chk(seg16, 16'h0000);
    chk(seg7, 16'h0000);
    seen = 1'b0;
    repeat (300) @(posedge clk_sys_in) seen = seen | clk_copy | (|den);
    chk({15'h0, seen}, 16'h0000);
  endtask
  task automatic t_config();
    wr(ADDR_PLANE0_BASE, 8'h41);
    wr(ADDR_PLANE1_BASE + 7'h0f, 8'h42);
    wr(ADDR_CONFIG, 8'hff);
    rd(ADDR_CONFIG, 8'h4d);
    rd(ADDR_PLANE0_BASE, DIGIT_BLANK);
    rd(ADDR_PLANE1_BASE + 7'h0f, DIGIT_BLANK);
    wr(7'h05, 8'h5a);
    rd(7'h05, 8'h00);
    wr(ADDR_CONFIG, 8'h00);
    rd(ADDR_CONFIG, 8'h00);
  endtask
  task automatic t_copy();
    int ne;
    int nc;
    logic pe;
    logic pc;
    @(posedge clk_sys_in);
    ext_clock_select_in <= 1'b1;
    ext_run <= 1'b1;
    repeat (100) @(posedge clk_sys_in);
    ne = 0;
    nc = 0;
    pe = ext_clk;
    pc = clk_copy;
    repeat (1600) @(posedge clk_sys_in) begin
      if (ext_clk && !pe) ne++;
      if (clk_copy === 1'b1 && pc === 1'b0) nc++;
      pe = ext_clk;
      pc = clk_copy;
    end
    chk(16'(nc + 1 - ne) >> 1, 16'h0000);
  endtask
  // Waits for a whole phase-one interval and returns its length and the decimal point in both phases.
  task automatic meas(output int len, output logic dp1, output logic dp0);
    int i;
    for (i = 0; i < 3 * PH && phase !== 1'b1; i++) @(posedge clk_sys_in);
    repeat (10) @(posedge clk_sys_in);
    dp1 = dp;
    for (len = 10; len < 3 * PH && phase === 1'b1; len++) @(posedge clk_sys_in);
    repeat (10) @(posedge clk_sys_in);
    dp0 = dp;
  endtask
  task automatic t_blink();
    int len;
    logic d1;
    logic d0;
    wr(ADDR_PLANE0_BASE, 8'h88);
    wr(ADDR_PLANE1_BASE, 8'h00);
    wr(ADDR_CONFIG, 8'h18);
    meas(len, d1, d0);
    rng(16'(len), PH);
    chk({14'h0, d1, d0}, 16'h0001);
    wr(ADDR_CONFIG, 8'h1c);
    meas(len, d1, d0);
    rng(16'(len), PH / 2);
    meas(len, d1, d0);
    wr(ADDR_CONFIG, 8'h1c);
    rd(ADDR_CONFIG, 8'h0c);
    wr(ADDR_CONFIG, 8'h04);
    d1 = 1'b1;
    repeat (2 * PH) @(posedge clk_sys_in) d1 = d1 & dp;
    chk({15'h0, d1}, 16'h0001);
    chk(seg7, 16'h00ff);
  endtask
  task automatic pulses2();
    logic [15:0] n;
    n = pulses;
    for (int i = 0; i < 3 * DIGIT_TICKS * TC && pulses < n + 16'h2; i++) @(posedge clk_sys_in);
  endtask
  task automatic t_pwm();
    // Raising the duty while the digit is dark would add a second rise and shorten the measured period.
    for (int i = 0; i < DIGIT_TICKS * TC && den[0] !== 1'b1; i++) @(posedge clk_sys_in);
    wr(ADDR_GLOBAL_BRIGHT, 8'hf3);
    pulses2();
    rng(w_main, 4 * SC);
    rng(w_extra, 4 * SC);
    rng(per_main, DIGIT_TICKS * TC);
    wr(ADDR_BRIGHT_BASE, 8'h3f);
    wr(ADDR_BRIGHT_BASE + 7'h04, 8'h01);
    wr(ADDR_CONFIG, 8'h40);
    pulses2();
    rng(w_main, 15 * SC);
    rng(w_extra, 2 * SC);
  endtask
  task automatic t_scan();
    int i;
    wr(ADDR_SCAN_LIMIT, 8'h07);
    repeat (3) @(posedge clk_sys_in);
    chk({8'h00, kmask}, 16'h00ff);
    wr(ADDR_SCAN_LIMIT, 8'h01);
    repeat (3) @(posedge clk_sys_in);
    chk({8'h00, kmask}, 16'h0003);
    for (i = 0; i < 2 * DIGIT_TICKS * TC && den !== 8'h02; i++) @(posedge clk_sys_in);
    chk({8'h00, den}, 16'h0002);
    for (i = 0; i < 2 * DIGIT_TICKS * TC && den !== 8'h01; i++) @(posedge clk_sys_in);
    chk({8'h00, den}, 16'h0001);
  endtask
  initial begin
    repeat (10) @(posedge clk_sys_in);
    rstn_in <= 1'b1;
    t_reset();
    t_config();
    t_copy();
    t_blink();
    t_pwm();
    t_scan();
    report_and_stop();
  end
endmodule
